// ### cat_cfg.svh
// Constants for the counter array timebase.
`ifndef CAT_CFG_SVH
`define CAT_CFG_SVH
`define CAT_SEL_DIV12    3'h0
`define CAT_SEL_DIV4     3'h1
`define CAT_SEL_T0OVF    3'h2
`define CAT_SEL_EXTIN    3'h3
`define CAT_SEL_SYSCLK   3'h4
`define CAT_SEL_OSCDIV8  3'h5
`define CAT_DIV12_LAST   4'hB
`define CAT_DIV4_LAST    2'h3
`define CAT_OSC_DIV_LAST 3'h7
`define CAT_COUNT_RESET  16'h0000
`define CAT_COUNT_MAX    16'hFFFF
`define CAT_PIN_IDLE     1'h1
`define CAT_OSC_IDLE     1'h0
`define CAT_IRQ_EN_BIT   7
`define CAT_NUM_MODULES  5
`endif

// ### cat_pkg.sv
// Types shared by the counter array timebase.
package cat_pkg;
    typedef logic [2:0] cat_sel_t;
    typedef struct packed {
        logic       overflow_irq_enable;
        logic       idle_stop_select;
        cat_sel_t   timebase_select;
    } cat_mode_s;
    typedef struct packed {
        logic       rd_low;
        logic       rd_high;
        logic       clr_flag;
    } cat_sw_s;
endpackage

// ### cat_timebase.sv
// Counter array timebase: 16-bit counter, source select, snapshot, overflow.
// Functional notes
// RQ1: The counter is a 16-bit up-counter read as a low and a high byte.
// RQ2: A low byte read latches the high byte, and high byte reads return it.
// RQ3: Byte reads never disturb counting.
// RQ4: A three-bit select picks div12, div4, timer 0, ext falls, clk, osc/8.
// RQ5: Only external falling edges count, at most a quarter of clock rate.
// RQ6: The oscillator divided by eight is synchronised before it counts.
// RQ7: A wrap from all ones to zero sets the overflow flag.
// RQ8: The overflow flag requests an interrupt only when its enable is set.
// RQ9: The flag is cleared only by software, never by vectoring.
// RQ10: Requests pass only when global and array enables are both set.
// RQ11: With idle stop clear the counter runs on in idle mode.
// RQ12: The count is the shared timebase of five capture/compare modules.
// RQ13: The selected tick is the count rate given to the modules.
// RQ14: With idle stop set the counter holds in idle and resumes after.
// RQ15: A reserved select code stops the counter.
`timescale 1ns/1ps
`include "cat_cfg.svh"
module cat_timebase
(
    // Clock, reset and enable.
    input  wire logic               mclk_in,
    input  wire logic               reset_n_in,
    input  wire logic               clk_en_in,
    // Software access and configuration.
    input  wire cat_pkg::cat_mode_s mode_in,
    input  wire cat_pkg::cat_sw_s   sw_in,
    input  wire logic               global_irq_enable_in,
    input  wire logic               array_irq_enable_in,
    input  wire logic               cpu_idle_in,
    // Count sources.
    input  wire logic               timer0_ovf_in,
    input  wire logic               external_count_input_in,
    input  wire logic               ext_osc_in,
    // Results.
    output      logic [7:0]         count_low_byte_out,
    output      logic [7:0]         count_high_byte_out,
    output      logic [15:0]        timebase_out,
    output      logic               count_tick_out,
    output      logic               count_overflow_flag_out,
    output      logic               irq_out
);
    import cat_pkg::*;

    // Counter state, high byte snapshot and the sticky overflow flag.
    logic [15:0] count_q;
    logic [7:0]  snap_q;
    logic        flag_q;
    // Shared prescaler and the divider in the oscillator's own clock.
    logic [3:0]  presc_q;
    logic [2:0]  osc_div_q;
    // Synchronised levels of the slow inputs and their previous values.
    logic        pin_lvl_w;
    logic        pin_prev_w;
    logic        osc_lvl_w;
    logic        osc_prev_w;
    // Decoded strobes.
    logic        run_w;
    logic        tick_w;
    logic        div12_w;
    logic        div4_w;
    logic        pin_fall_w;
    logic        osc_rise_w;
    logic        wrap_w;

    ////////////////////////////////////////////////////////////////////////
    // Free-running divider in the external oscillator's own clock.
    always_ff @(posedge ext_osc_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            osc_div_q <= 3'h0;
        else
            osc_div_q <= osc_div_q + 3'h1;
    end

    // Two-stage synchronisers for the external count pin and osc/8. Each
    // starts at the idle level of its source, so reset makes no false edge.
    cat_edge_sync #(.IDLE_LEVEL(`CAT_PIN_IDLE)) pin_sync_u
    (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .clk_en_in  (clk_en_in),
        .async_in   (external_count_input_in),
        .level_out  (pin_lvl_w),
        .prev_out   (pin_prev_w)
    );

    // The divided oscillator is slow enough to be sampled as a level.
    cat_edge_sync #(.IDLE_LEVEL(`CAT_OSC_IDLE)) osc_sync_u
    (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .clk_en_in  (clk_en_in),
        .async_in   (osc_div_q[2]), // RQ6
        .level_out  (osc_lvl_w),
        .prev_out   (osc_prev_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Source decode and the single count tick.
    assign div12_w    = (presc_q == `CAT_DIV12_LAST);
    assign div4_w     = (presc_q[1:0] == `CAT_DIV4_LAST);
    assign pin_fall_w = pin_prev_w & ~pin_lvl_w; // RQ5
    assign osc_rise_w = ~osc_prev_w & osc_lvl_w; // RQ6
    assign run_w      = clk_en_in & ~(cpu_idle_in & mode_in.idle_stop_select);
    assign tick_w     = run_w & (
        (mode_in.timebase_select == `CAT_SEL_DIV12)   ? div12_w :
        (mode_in.timebase_select == `CAT_SEL_DIV4)    ? div4_w :
        (mode_in.timebase_select == `CAT_SEL_T0OVF)   ? timer0_ovf_in :
        (mode_in.timebase_select == `CAT_SEL_EXTIN)   ? pin_fall_w :
        (mode_in.timebase_select == `CAT_SEL_SYSCLK)  ? 1'b1 :
        (mode_in.timebase_select == `CAT_SEL_OSCDIV8) ? osc_rise_w :
        1'b0); // RQ4 RQ11 RQ14 RQ15
    assign wrap_w = tick_w & (count_q == `CAT_COUNT_MAX);

    // Prescaler for the divide-by-12 and divide-by-4 sources.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            presc_q <= 4'h0;
        else if (run_w)
            presc_q <= div12_w ? 4'h0 : presc_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, snapshot and overflow flag.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            count_q <= `CAT_COUNT_RESET;
            snap_q  <= 8'h00;
            flag_q  <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (tick_w)
                count_q <= count_q + 16'h0001; // RQ1 RQ3
            if (sw_in.rd_low)
                snap_q <= count_q[15:8]; // RQ2
            if (wrap_w)
                flag_q <= 1'b1; // RQ7
            else if (sw_in.clr_flag)
                flag_q <= 1'b0; // RQ9
        end
    end

    // Read data and shared timebase outputs.
    assign count_low_byte_out      = count_q[7:0];
    assign count_high_byte_out     = snap_q; // RQ2
    assign timebase_out            = count_q; // RQ12
    assign count_tick_out          = tick_w; // RQ13
    assign count_overflow_flag_out = flag_q;
    assign irq_out = flag_q & mode_in.overflow_irq_enable // RQ8
                   & global_irq_enable_in & array_irq_enable_in; // RQ10

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    count_step_a: assert property (reset_n_in && clk_en_in && // RQ1
        tick_w |=> count_q == $past(count_q) + 16'h0001)
        else $error("Counter did not advance on a tick.");
    snap_load_a: assert property (reset_n_in && clk_en_in && // RQ2
        sw_in.rd_low |=> count_high_byte_out == $past(count_q[15:8]))
        else $error("High byte snapshot not taken.");
    no_tick_hold_a: assert property (!tick_w |=> $stable(count_q)) // RQ3
        else $error("Counter moved without a tick.");
    sysclk_run_a: assert property (run_w && // RQ4
        mode_in.timebase_select == `CAT_SEL_SYSCLK |-> tick_w)
        else $error("System clock source did not tick.");
    reserved_stop_a: assert property (mode_in.timebase_select[2:1] == 2'h3
        |-> !tick_w) // RQ15
        else $error("Reserved source advanced the counter.");
    idle_hold_a: assert property (cpu_idle_in && // RQ14
        mode_in.idle_stop_select |-> !tick_w)
        else $error("Counter ran in idle with stop selected.");
    wrap_flag_a: assert property (clk_en_in && wrap_w |=> // RQ7
        flag_q && count_q == `CAT_COUNT_RESET)
        else $error("Wrap did not set the flag.");
    flag_sticky_a: assert property (flag_q && !sw_in.clr_flag // RQ9
        |=> flag_q)
        else $error("Flag cleared without software.");
    irq_gate_a: assert property (irq_out == (flag_q && // RQ8
        mode_in.overflow_irq_enable && global_irq_enable_in &&
        array_irq_enable_in)) // RQ10
        else $error("Interrupt gating wrong.");
    div12_gap_a: assert property (clk_en_in && div12_w && run_w |=> // RQ4
        !div12_w [*8])
        else $error("Divide-by-12 tick too early.");
    div4_gap_a: assert property (run_w && div4_w |=> // RQ4
        !div4_w [*3])
        else $error("Divide-by-4 tick too early.");
    flag_clear_a: assert property (reset_n_in && clk_en_in && // RQ9
        sw_in.clr_flag && !wrap_w |=> !flag_q)
        else $error("Software clear did not drop the flag.");
    pin_tick_a: assert property (run_w && // RQ5
        mode_in.timebase_select == `CAT_SEL_EXTIN |-> tick_w == pin_fall_w)
        else $error("External pin fall not counted once.");
    osc_tick_a: assert property (run_w && // RQ6
        mode_in.timebase_select == `CAT_SEL_OSCDIV8 |-> tick_w == osc_rise_w)
        else $error("Oscillator tick not taken from its edge.");
    freeze_hold_a: assert property (!clk_en_in |=> // RQ1
        $stable(count_q) && $stable(snap_q) && $stable(flag_q))
        else $error("State moved with the clock enable low.");

    // Main scenarios that the checks above should see at least once.
    wrap_c: cover property (wrap_w);
    pin_fall_c: cover property (pin_fall_w &&
        mode_in.timebase_select == `CAT_SEL_EXTIN);
    osc_c: cover property (osc_rise_w &&
        mode_in.timebase_select == `CAT_SEL_OSCDIV8);
    irq_c: cover property (irq_out);
    idle_c: cover property (cpu_idle_in && mode_in.idle_stop_select);
endmodule

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser with a delayed copy for edge detection. Only the
// second flop reads the first, so a metastable first stage never reaches
// the edge logic.
module cat_edge_sync
#(
    parameter logic IDLE_LEVEL = 1'h0
)
(
    // Clock, reset and enable.
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    input  wire logic clk_en_in,
    // Asynchronous level in, settled level and its previous value out.
    input  wire logic async_in,
    output      logic level_out,
    output      logic prev_out
);
    logic [1:0] sync_q;
    logic       prev_q;

    // Shift the input through two stages and keep one delayed copy.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync_q <= {2{IDLE_LEVEL}};
            prev_q <= IDLE_LEVEL;
        end
        else if (clk_en_in)
        begin
            sync_q <= {sync_q[0], async_in};
            prev_q <= sync_q[1];
        end
    end

    // Settled level and the level one clock earlier.
    assign level_out = sync_q[1];
    assign prev_out  = prev_q;
endmodule

// ### cat_far_end.sv
// Far side model: external count pin and external oscillator.
`timescale 1ns/1ps
module cat_far_end
(
    // Clock and control.
    input  wire logic mclk_in,
    input  wire logic run_in,
    // Driven pins.
    output logic      ext_pin_out,
    output logic      osc_out
);
    logic [1:0] gap_q = 2'h0;
    logic       pin_q = 1'b1;
    logic       osc_q = 1'b0;
    // Free oscillator, unrelated in phase to the system clock.
    always #35 osc_q = ~osc_q;
    // Toggle every four clocks, so falls stay within a quarter rate.
    always @(posedge mclk_in)
    begin
        if (run_in)
        begin
            gap_q <= gap_q + 2'h1;
            if (gap_q == 2'h3)
                pin_q <= ~pin_q;
        end
    end
    // Each pin has a single driver.
    assign ext_pin_out = pin_q;
    assign osc_out     = osc_q;
endmodule

// ### counter_array_timebase_test.sv
// Self-checking bench for the counter array timebase.
`timescale 1ns/1ps
module counter_array_timebase_test;
    import cat_pkg::*;
    logic        mclk_in = 1'b0, reset_n_in = 1'b0, g_en = 1'b0;
    logic        a_en = 1'b0, idle = 1'b0, t0 = 1'b0, run = 1'b0;
    logic        en = 1'b1, tick;
    logic        ext, osc, flag, irq;
    cat_mode_s   mode = 5'h04;
    cat_sw_s     sw = 3'h0;
    logic [7:0]  lo, hi;
    logic [15:0] tb, a;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    cat_timebase dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .clk_en_in(en), .mode_in(mode), .sw_in(sw),
        .global_irq_enable_in(g_en), .array_irq_enable_in(a_en),
        .cpu_idle_in(idle), .timer0_ovf_in(t0),
        .external_count_input_in(ext), .ext_osc_in(osc),
        .count_low_byte_out(lo), .count_high_byte_out(hi),
        .timebase_out(tb), .count_tick_out(tick),
        .count_overflow_flag_out(flag),
        .irq_out(irq));
    cat_far_end far_u (.mclk_in(mclk_in), .run_in(run), .ext_pin_out(ext),
        .osc_out(osc));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard.
    always #50 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Compares one value and reports a mismatch.
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, g);
            err_count++;
        end
    endtask
    // Counts increments over a window with the given mode and idle level.
    task automatic meas(string n, logic [4:0] m, logic i, logic [15:0] e);
        @(posedge mclk_in) begin mode <= m; idle <= i; end
        @(negedge mclk_in) a = tb;
        repeat (24) @(negedge mclk_in);
        chk(n, e, tb - a);
        @(posedge mclk_in) idle <= 1'b0;
    endtask
    // Low read latches the high byte, which then holds while counting.
    task automatic t_snap();
        @(posedge mclk_in) begin mode <= 5'h04; sw <= 3'h4; end
        @(negedge mclk_in) a = tb;
        @(posedge mclk_in) sw <= 3'h0;
        repeat (300) @(negedge mclk_in);
        chk("snap_hold", {8'h00, a[15:8]}, {8'h00, hi});
        chk("count_run", 16'h012C, tb - a);
        chk("low_live", {8'h00, tb[7:0]}, {8'h00, lo});
    endtask
    // Timer 0 pulses, then external pin falls from the far side model.
    task automatic t_src();
        @(posedge mclk_in) mode <= 5'h02;
        @(negedge mclk_in) a = tb;
        repeat (3)
        begin
            @(posedge mclk_in) t0 <= 1'b1;
            @(negedge mclk_in);
            chk("t0_tick", 16'h0001, {15'h0, tick});
            @(posedge mclk_in) t0 <= 1'b0;
        end
        @(negedge mclk_in) chk("t0_count", 16'h0003, tb - a);
        @(posedge mclk_in) mode <= 5'h03;
        @(negedge mclk_in) a = tb;
        @(posedge mclk_in) run <= 1'b1;
        repeat (80) @(posedge mclk_in);
        run <= 1'b0;
        repeat (10) @(negedge mclk_in);
        chk("ext_falls", 16'h000A, tb - a);
        @(posedge mclk_in) mode <= 5'h05;
        repeat (5) @(negedge mclk_in);
        a = tb;
        repeat (560) @(negedge mclk_in);
        chk("osc_rate", 16'h1, 16'(tb - a >= 16'd99 && tb - a <= 16'd101));
    endtask
    // Wrap sets the flag; each enable gates the request; software clears.
    task automatic t_ovf();
        @(posedge mclk_in) begin mode <= 5'h14; g_en <= 1'b1; a_en <= 1'b1; end
        while (tb !== 16'hFFFF) @(negedge mclk_in);
        chk("flag_pre", 16'h0000, {15'h0, flag});
        @(negedge mclk_in) chk("wrap", 16'h0000, tb);
        chk("flag_irq", 16'h0003, {14'h0, flag, irq});
        @(posedge mclk_in) g_en <= 1'b0;
        @(negedge mclk_in) chk("irq_glob", 16'h0002, {14'h0, flag, irq});
        @(posedge mclk_in) begin g_en <= 1'b1; a_en <= 1'b0; end
        @(negedge mclk_in) chk("irq_arr", 16'h0002, {14'h0, flag, irq});
        @(posedge mclk_in) begin a_en <= 1'b1; mode <= 5'h04; end
        @(negedge mclk_in) chk("irq_ecf", 16'h0002, {14'h0, flag, irq});
        @(posedge mclk_in) sw <= 3'h1;
        @(posedge mclk_in) sw <= 3'h0;
        @(negedge mclk_in) chk("flag_clr", 16'h0000, {14'h0, flag, irq});
    endtask
    // Clock enable low freezes the count; it resumes when raised again.
    task automatic t_freeze();
        @(posedge mclk_in) en <= 1'b0;
        @(negedge mclk_in) a = tb;
        repeat (24) @(negedge mclk_in);
        chk("frozen", 16'h0000, tb - a);
        @(posedge mclk_in) en <= 1'b1;
        @(negedge mclk_in) a = tb;
        repeat (24) @(negedge mclk_in);
        chk("resumed", 16'h0018, tb - a);
    endtask
    // Main sequence.
    initial
    begin
        repeat (20) @(negedge mclk_in);
        chk("reset_vals", 16'h0000, tb | {hi, 7'h0, flag});
        @(posedge mclk_in) reset_n_in <= 1'b1;
        meas("sysclk", 5'h04, 1'b0, 16'd24);
        meas("div12", 5'h00, 1'b0, 16'd2);
        meas("div4", 5'h01, 1'b0, 16'd6);
        meas("resv_6", 5'h06, 1'b0, 16'd0);
        meas("resv_7", 5'h07, 1'b0, 16'd0);
        meas("idle_run", 5'h04, 1'b1, 16'd24);
        meas("idle_hold", 5'h0C, 1'b1, 16'd0);
        meas("idle_end", 5'h0C, 1'b0, 16'd24);
        t_freeze();
        t_snap();
        t_src();
        t_ovf();
        complete_run();
    end
endmodule
